// file: logic/wsa_defs.svh
// Constants for the warning status aggregator: register offsets,
// warning bit positions and reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef WSA_DEFS_SVH
`define WSA_DEFS_SVH

// Register offsets (word addresses on the plain register port)
`define WSA_OFS_WARN_LIVE      4'h0
`define WSA_OFS_WARN_SNAP      4'h1
`define WSA_OFS_APP_LIVE       4'h2
`define WSA_OFS_APP_SNAP       4'h3
`define WSA_OFS_STATUS         4'h4
`define WSA_OFS_CTRL           4'h5

// General warning word bit positions
`define WSA_B_OVERLOAD         0
`define WSA_B_OVL_A            1
`define WSA_B_OVL_B            2
`define WSA_B_HEATSINK         3
`define WSA_B_INSIDE           4
`define WSA_B_LIMIT            5
`define WSA_B_INIT             6
`define WSA_B_MOTOR_TEMP       7
`define WSA_B_PHASE            8
`define WSA_B_BREAKER          9
`define WSA_B_FREQ_LIM         10
`define WSA_B_AIN1             11
`define WSA_B_AIN2             12
`define WSA_B_BUS_SLAVE        13
`define WSA_B_DC_UNDER         14
`define WSA_B_APP_CHAIN        15

// Application warning word bit positions
`define WSA_AB_BELT            0
`define WSA_AB_SERVICE         6
`define WSA_AB_USER1           7
`define WSA_AB_USER2           8

// Reset values
`define WSA_WORD_RST           16'h0000
`define WSA_CTRL_RST           2'h0

`endif

// file: logic/wsa_pkg.sv
// Types for the warning status aggregator.
// Assumes wsa_defs.svh is on the include path.
`include "wsa_defs.svh"

package wsa_pkg;

  // Raw warning conditions, already synchronous to the core clock
  typedef struct packed {
    logic       overload_window_a;
    logic       overload_window_b;
    logic       heatsink_temp_warn;
    logic       inside_temp_warn;
    logic       limit_active;
    logic       init_phase;
    logic       motor_temp_warn;
    logic       phase_missing;
    logic       motor_breaker_trip;
    logic       freq_limit_active;
    logic       analog_in1_low;
    logic       analog_in2_low;
    logic       bus_slave_error;
    logic       dc_link_undervolt;
  } wsa_gen_cond_t;

  typedef struct packed {
    logic       belt_warn;
    logic       service_dc_expired;
    logic       service_fan_expired;
    logic       user_warn1;
    logic       user_app_warning_chain;
  } wsa_app_cond_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic       wr;
    logic       rd;
  } wsa_reg_req_t;

  typedef enum logic [1:0] {
    WSA_SNAP_EMPTY = 2'b01,
    WSA_SNAP_HELD  = 2'b10
  } wsa_snap_st_t;

  typedef struct packed {
    logic [15:0]  warn_live;
    logic [15:0]  warn_snap;
    logic [15:0]  app_live;
    logic [15:0]  app_snap;
    wsa_snap_st_t snap_st;
    logic         snap_lock;
    logic         fault_d;
    logic [15:0]  rdata;
    logic         gen_warn;
    logic         app_warn;
  } wsa_state_t;

endpackage : wsa_pkg

// file: logic/wsa_top.sv
// Warning status aggregator: builds the general and application warning
// words, their fault snapshots, summary warning signals and a register port.
// Assumes all condition inputs and the fault event are synchronous to the
// core clock, driven by the detection logic of the device.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "wsa_defs.svh"

module wsa_top (
  // Clock and reset
  input  wire logic                  I_CORE_CLK,
  input  wire logic                  I_RST_N,
  // Warning conditions
  input  wire wsa_pkg::wsa_gen_cond_t I_GEN_COND,
  input  wire wsa_pkg::wsa_app_cond_t I_APP_COND,
  // Fault shutdown event, level or pulse; a rising edge captures while the snapshot is unlocked
  input  wire logic                  I_FAULT_SHUTDOWN,
  // Register port
  input  wire wsa_pkg::wsa_reg_req_t I_REG_REQ,
  output logic [15:0]                O_REG_RDATA,
  // Summary warning signals
  output logic                       O_GEN_WARNING,
  output logic                       O_APP_WARNING
);
  import wsa_pkg::*;

  wsa_state_t st_r;
  wsa_state_t st_nxt;
  logic [15:0] gen_w;
  logic [15:0] app_w;
  logic        fault_rise;

  always_comb begin
    gen_w = `WSA_WORD_RST;
    app_w = `WSA_WORD_RST;
    app_w[`WSA_AB_BELT]    = I_APP_COND.belt_warn;
    app_w[`WSA_AB_SERVICE] = I_APP_COND.service_dc_expired |
                             I_APP_COND.service_fan_expired;
    app_w[`WSA_AB_USER1]   = I_APP_COND.user_warn1;
    app_w[`WSA_AB_USER2]   = I_APP_COND.user_app_warning_chain;
    gen_w[`WSA_B_OVL_A]      = I_GEN_COND.overload_window_a;
    gen_w[`WSA_B_OVL_B]      = I_GEN_COND.overload_window_b;
    gen_w[`WSA_B_OVERLOAD]   = I_GEN_COND.overload_window_a |
                               I_GEN_COND.overload_window_b;
    gen_w[`WSA_B_HEATSINK]   = I_GEN_COND.heatsink_temp_warn;
    gen_w[`WSA_B_INSIDE]     = I_GEN_COND.inside_temp_warn;
    gen_w[`WSA_B_LIMIT]      = I_GEN_COND.limit_active;
    gen_w[`WSA_B_INIT]       = I_GEN_COND.init_phase;
    gen_w[`WSA_B_MOTOR_TEMP] = I_GEN_COND.motor_temp_warn;
    gen_w[`WSA_B_PHASE]      = I_GEN_COND.phase_missing;
    gen_w[`WSA_B_BREAKER]    = I_GEN_COND.motor_breaker_trip;
    gen_w[`WSA_B_FREQ_LIM]   = I_GEN_COND.freq_limit_active;
    gen_w[`WSA_B_AIN1]       = I_GEN_COND.analog_in1_low;
    gen_w[`WSA_B_AIN2]       = I_GEN_COND.analog_in2_low;
    gen_w[`WSA_B_BUS_SLAVE]  = I_GEN_COND.bus_slave_error;
    gen_w[`WSA_B_DC_UNDER]   = I_GEN_COND.dc_link_undervolt;
    gen_w[`WSA_B_APP_CHAIN]  = |app_w;

    fault_rise = I_FAULT_SHUTDOWN & ~st_r.fault_d;

    st_nxt = st_r;
    st_nxt.fault_d = I_FAULT_SHUTDOWN;
    // live words follow conditions each clock
    st_nxt.warn_live = gen_w;
    st_nxt.app_live  = app_w;
    // summary from the registered word's source
    st_nxt.gen_warn = |gen_w;
    st_nxt.app_warn = |app_w;

    // Lock keeps the picture held when it was set; software may rearm
    // capture both words on fault shutdown
    if (fault_rise && !st_r.snap_lock) begin
      st_nxt.app_snap  = app_w;
      st_nxt.warn_snap = gen_w;
      st_nxt.snap_st   = WSA_SNAP_HELD;
    end

    // Control register: bit0 locks snapshot, bit1 rearm pulse
    if (I_REG_REQ.wr && I_REG_REQ.addr == `WSA_OFS_CTRL) begin
      st_nxt.snap_lock = I_REG_REQ.wdata[0];
      if (I_REG_REQ.wdata[1] && !fault_rise) begin
        st_nxt.snap_st = WSA_SNAP_EMPTY;
      end
    end

    st_nxt.rdata = 16'h0000;
    if (I_REG_REQ.rd) begin
      unique case (I_REG_REQ.addr)
        `WSA_OFS_WARN_LIVE: st_nxt.rdata = st_r.warn_live;
        `WSA_OFS_WARN_SNAP: st_nxt.rdata = st_r.warn_snap;
        `WSA_OFS_APP_LIVE:  st_nxt.rdata = st_r.app_live;
        `WSA_OFS_APP_SNAP:  st_nxt.rdata = st_r.app_snap;
        `WSA_OFS_STATUS:    st_nxt.rdata = {14'h0000,
                              st_r.snap_st == WSA_SNAP_HELD,
                              st_r.gen_warn};
        `WSA_OFS_CTRL:      st_nxt.rdata = {15'h0000, st_r.snap_lock};
        default:            st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      st_r.warn_live <= `WSA_WORD_RST;
      st_r.warn_snap <= `WSA_WORD_RST;
      st_r.app_live  <= `WSA_WORD_RST;
      st_r.app_snap  <= `WSA_WORD_RST;
      st_r.snap_st   <= WSA_SNAP_EMPTY;
      st_r.snap_lock <= 1'b0;
      st_r.fault_d   <= 1'b0;
      st_r.rdata     <= 16'h0000;
      st_r.gen_warn  <= 1'b0;
      st_r.app_warn  <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_REG_RDATA   = st_r.rdata;
  assign O_GEN_WARNING = st_r.gen_warn;
  assign O_APP_WARNING = st_r.app_warn;

endmodule : wsa_top

// file: bench/wsa_top_monitor.sv
// Port checker for the warning status aggregator.
// Assumes binding into wsa_top on the core clock.
`timescale 1ns/10ps
module wsa_top_monitor (
  // Inputs
  input wire logic                   I_CORE_CLK,
  input wire logic                   I_RST_N,
  input wire wsa_pkg::wsa_gen_cond_t I_GEN_COND,
  input wire wsa_pkg::wsa_app_cond_t I_APP_COND,
  input wire logic                   I_FAULT_SHUTDOWN,
  input wire wsa_pkg::wsa_reg_req_t  I_REG_REQ,
  // Outputs
  input wire logic [15:0]            O_REG_RDATA,
  input wire logic                   O_GEN_WARNING,
  input wire logic                   O_APP_WARNING
);
  function automatic logic [15:0] gen_w(logic [13:0] g, logic [4:0] a);
    logic [15:0] w;
    w[0] = g[13] | g[12];
    for (int i = 0; i < 14; i++) w[i+1] = g[13-i];
    w[15] = |a;
    return w;
  endfunction : gen_w

  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  a_gen_warn_out: assert property (
    $past(I_RST_N) |-> O_GEN_WARNING == (|$past(I_GEN_COND) ||
    |$past(I_APP_COND))) else $error("general warning output wrong");
  a_app_warn_out: assert property (
    $past(I_RST_N) |-> O_APP_WARNING == |$past(I_APP_COND))
    else $error("application warning output wrong");
  a_gen_live_read: assert property (
    I_REG_REQ.rd && I_REG_REQ.addr == 4'h0 && $past(I_RST_N) |=>
    O_REG_RDATA == gen_w($past(I_GEN_COND, 2), $past(I_APP_COND, 2)))
    else $error("general live word wrong");
  a_app_live_read: assert property (
    I_REG_REQ.rd && I_REG_REQ.addr == 4'h2 && $past(I_RST_N) |=>
    O_REG_RDATA[15:9] == 7'h00 && O_REG_RDATA[5:1] == 5'h00 &&
    O_REG_RDATA[8] == $past(I_APP_COND.user_app_warning_chain, 2) &&
    O_REG_RDATA[7] == $past(I_APP_COND.user_warn1, 2) &&
    O_REG_RDATA[6] == ($past(I_APP_COND.service_dc_expired, 2) |
    $past(I_APP_COND.service_fan_expired, 2)) &&
    O_REG_RDATA[0] == $past(I_APP_COND.belt_warn, 2))
    else $error("application live word wrong");
  a_overload_sum: assert property (
    I_REG_REQ.rd && I_REG_REQ.addr == 4'h0 |=>
    O_REG_RDATA[0] == (O_REG_RDATA[1] | O_REG_RDATA[2]))
    else $error("overall overload bit wrong");
  a_chain_bit: assert property (
    I_REG_REQ.rd && I_REG_REQ.addr == 4'h0 && $past(I_RST_N) |=>
    O_REG_RDATA[15] == |$past(I_APP_COND, 2))
    else $error("chain bit wrong");
  a_unmapped_zero: assert property (
    I_REG_REQ.rd && I_REG_REQ.addr > 4'h5 |=> O_REG_RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_quiet: assert property (
    !I_REG_REQ.rd |=> O_REG_RDATA == 16'h0000)
    else $error("read data outside answer cycle");

  c_fault_edge: cover property ($rose(I_FAULT_SHUTDOWN));
  c_snap_read: cover property (I_REG_REQ.rd && I_REG_REQ.addr == 4'h1);
  c_both_warn: cover property (O_GEN_WARNING && O_APP_WARNING);
endmodule : wsa_top_monitor

bind wsa_top wsa_top_monitor wsa_top_monitor_inst (
  .I_CORE_CLK, .I_RST_N, .I_GEN_COND, .I_APP_COND, .I_FAULT_SHUTDOWN,
  .I_REG_REQ, .O_REG_RDATA, .O_GEN_WARNING, .O_APP_WARNING);

// file: bench/test_warning_status_aggregator.sv
// Self-checking bench for the warning status aggregator.
// Assumes a one-cycle registered read port and the bound checker.
`timescale 1ns/10ps
module test_warning_status_aggregator;
  import wsa_pkg::*;
  logic          clk;
  logic          rst_n;
  logic          flt;
  wsa_gen_cond_t gc;
  wsa_app_cond_t ac;
  wsa_reg_req_t  req;
  logic [15:0]   rdata;
  logic          gw;
  logic          aw;
  logic [15:0]   q[$];
  logic          pend;
  int            fail_count;
  int            compares;
  int            cyc;
  logic [18:0]   v;

  wsa_top wsa_top_inst (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_GEN_COND(gc),
    .I_APP_COND(ac), .I_FAULT_SHUTDOWN(flt), .I_REG_REQ(req),
    .O_REG_RDATA(rdata), .O_GEN_WARNING(gw), .O_APP_WARNING(aw));

  function automatic logic [15:0] ge(logic [18:0] x);
    logic [15:0] w;
    for (int i = 0; i < 14; i++) w[i+1] = x[18-i];
    w[0] = x[18] | x[17];
    w[15] = |x[4:0];
    return w;
  endfunction : ge

  function automatic logic [15:0] ae(logic [18:0] x);
    return {7'h00, x[0], x[1], x[3] | x[2], 5'h00, x[4]};
  endfunction : ae

  task automatic end_of_test();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [15:0] d, input logic [15:0] e);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w) q.push_back(e);
    @(posedge clk);
    req <= '0;
  endtask : bus

  // Drive conditions, poke a read-only word, then read both live words
  task automatic apply(input logic [18:0] x);
    @(posedge clk);
    {gc, ac} <= x;
    bus(1'b1, 4'h0, 16'hffff, 16'h0000);
    bus(1'b0, 4'h0, 16'h0000, ge(x));
    bus(1'b0, 4'h2, 16'h0000, ae(x));
    // Conditions have stood for several cycles, so the pins are settled
    chk({15'h0000, gw}, {15'h0000, |ge(x)});
    chk({15'h0000, aw}, {15'h0000, |x[4:0]});
  endtask : apply

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pend) chk(rdata, q.pop_front());
    pend <= req.rd;
    if (cyc > 2000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    {rst_n, flt, gc, ac, req, pend, cyc} = '0;
    void'($urandom(32'hece1));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) bus(1'b0, 4'(i), 16'h0000, 16'h0000);
    bus(1'b0, 4'hf, 16'h0000, 16'h0000);
    chk({14'h0000, aw, gw}, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 19; i++) apply(19'h1 << i);
    $display("test single warnings done");
    repeat (20) apply(19'($urandom()));
    $display("test combined warnings done");
    v = 19'($urandom());
    apply(v);
    flt <= 1'b1;
    // Fault held high must not recapture while conditions move
    apply(~v);
    bus(1'b0, 4'h1, 16'h0000, ge(v));
    bus(1'b0, 4'h3, 16'h0000, ae(v));
    flt <= 1'b0;
    apply(~v);
    flt <= 1'b1;
    apply(v);
    bus(1'b0, 4'h1, 16'h0000, ge(~v));
    bus(1'b0, 4'h3, 16'h0000, ae(~v));
    $display("test snapshot done");
    // Lock keeps the held picture through a new fault edge
    bus(1'b0, 4'h4, 16'h0000, {14'h0000, 1'b1, |ge(v)});
    bus(1'b1, 4'h5, 16'h0001, 16'h0000);
    bus(1'b0, 4'h5, 16'h0000, 16'h0001);
    flt <= 1'b0;
    @(posedge clk);
    flt <= 1'b1;
    bus(1'b0, 4'h1, 16'h0000, ge(~v));
    // Unlock and rearm: status drops the held flag
    bus(1'b1, 4'h5, 16'h0002, 16'h0000);
    bus(1'b0, 4'h4, 16'h0000, {14'h0000, 1'b0, |ge(v)});
    bus(1'b0, 4'h5, 16'h0000, 16'h0000);
    $display("test lock done");
    // Mid-run reset clears the snapshot; fault low so no edge follows
    flt <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h1, 16'h0000, 16'h0000);
    bus(1'b0, 4'h4, 16'h0000, {15'h0000, |ge(v)});
    $display("test reset again done");
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule : test_warning_status_aggregator
